// File: pa_board.sv
// Purpose: Board model that resolves every shared port A pad.
// Assumes: Internal pull-ups hold any pad that nobody drives.
// Notes:   The device drive wins, so an open drain low always shows.
`timescale 1ns/10ps
module pa_board
   import pa_pkg::*;
(
   input  wire pa_pad_s            pad_o,
   input  wire logic [PA_NPIN-1:0] ext_val,
   input  wire logic [PA_NPIN-1:0] ext_en,
   output logic [PA_NPIN-1:0]      pad_in
);
   // A released pad reads high, so an idle reset pad never requests reset.
   always_comb
   begin
      for (int i = 0; i < PA_NPIN; i++)
      begin
         if (pad_o.oe[i])
            pad_in[i] = pad_o.out[i];
         else if (ext_en[i])
            pad_in[i] = ext_val[i];
         else
            pad_in[i] = 1'b1;
      end
   end
endmodule : pa_board

// File: pa_pin_mux.sv
// Purpose: Function select for the reset pad and port A bits zero to four.
// Assumes: Pad inputs are synchronous to clk; pads resolve their own wires.
// Notes:   Pad outputs are registered, so a select change shows one cycle later.
// Operation
// - Every reset returns each pin to GPIO and the reset pad to its reset role.
// - A low reset pad in reset mode resets the chip and holds it there.
// - The chip reset is released on a clock edge a fixed count after release.
// - The reset pad comes out of reset in its reset input role.
// - The reset pad as GPIO is only an input or an open drain output.
// - The reset pad as GPIO never resets the chip.
// - Power on, watchdog and software requests still reset the chip.
// - Each GPIO pin has its own direction bit.
// - A pin given to the PWM unit drives its PWM channel as an output.
// - A pin given to the fault input is an input that flags a fault to the PWM.
// - Pin functions come from the select controls of this integration block.
// - The timer channel goes to port A bit four, the only timer capable pin.
`timescale 1ns/10ps
module pa_pin_mux
   import pa_pkg::*;
#(
   parameter int HOLD_CYCLES = PA_RST_HOLD_CYC
)(
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire pa_bus_s              bus_i,
   output logic [PA_DW-1:0]          rdata,
   input  wire logic [PA_NPIN-1:0]   pad_in,
   output pa_pad_s                   pad_o,
   input  wire logic [PA_NPWM-1:0]   pwm_out,
   input  wire logic                 timer_out,
   input  wire logic                 timer_oe,
   output logic                      timer_in,
   output logic                      pwm_fault_in_one,
   output logic [PA_NPIN-1:0]        gpio_in,
   input  wire logic                 por_req,
   input  wire logic                 watchdog_reset,
   output logic                      chip_rst_n
);

   generate
      if (HOLD_CYCLES < 2)
      begin : g_bad
         $error("HOLD_CYCLES must be at least two");
      end
   endgenerate

   logic [7:0] data_reg;
   logic [7:0] dir_reg;
   logic [9:0] fsel_reg;
   logic       rst_gpio_reg;
   logic       sw_rst_reg;
   logic       rst_req;
   pa_pad_s    pad_next;
   logic       timer_next;
   logic       fault_next;
   logic [PA_DW-1:0] rdata_next;

   // Resolves the function of a pin; codes a pin cannot serve fall back to GPIO.
   function automatic pa_fn_e fn_of(input int pin, input logic [9:0] fsel);
      pa_fn_e f;
      f = PA_FN_GPIO;
      if (pin < PA_NFSEL)
      begin
         f = pa_fn_e'(fsel[pin*PA_FSEL_W +: PA_FSEL_W]);
         if ((f == PA_FN_PWM && !PA_PWM_MASK[pin]) ||
             (f == PA_FN_TIMER && !PA_TMR_MASK[pin]) ||
             (f == PA_FN_FAULT && !PA_FLT_MASK[pin]))
            f = PA_FN_GPIO;
      end
      return f;
   endfunction : fn_of

   function automatic logic wr_hit(input pa_bus_s b, input logic [3:0] ofs);
      return b.wr && (b.addr == ofs);
   endfunction : wr_hit

   // External reset path is gated off while the reset pad serves as GPIO.
   always_comb
   begin
      rst_req = por_req || watchdog_reset || sw_rst_reg;
      if (!rst_gpio_reg && !pad_in[PA_RST_PIN])
         rst_req = 1'b1;
   end

   pa_rst_seq #(
      .HOLD_CYCLES (HOLD_CYCLES)
   ) u_rst_seq (
      .clk     (clk),
      .nrst    (nrst),
      .req     (rst_req),
      .rst_n_o (chip_rst_n)
   );

   // Select and pad role controls; any chip reset puts them back to defaults.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         fsel_reg     <= PA_FSEL_RST;
         rst_gpio_reg <= PA_RGPIO_RST;
      end
      else if (!chip_rst_n)
      begin
         fsel_reg     <= PA_FSEL_RST;
         rst_gpio_reg <= PA_RGPIO_RST;
      end
      else
      begin
         if (wr_hit(bus_i, PA_OFS_FSEL))
            fsel_reg <= bus_i.wdata[9:0];
         if (wr_hit(bus_i, PA_OFS_RCTL))
            rst_gpio_reg <= bus_i.wdata[PA_RCTL_GPIO_BIT];
      end
   end

   // GPIO data and direction.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         data_reg <= PA_DATA_RST;
         dir_reg  <= PA_DIR_RST;
      end
      else if (!chip_rst_n)
      begin
         data_reg <= PA_DATA_RST;
         dir_reg  <= PA_DIR_RST;
      end
      else
      begin
         if (wr_hit(bus_i, PA_OFS_DATA))
            data_reg <= bus_i.wdata[7:0] & PA_PIN_MASK;
         if (wr_hit(bus_i, PA_OFS_DIR))
            dir_reg <= bus_i.wdata[7:0] & PA_PIN_MASK;
      end
   end

   // Software reset is a single cycle request; the sequencer stretches it.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sw_rst_reg <= 1'b0;
      else
         sw_rst_reg <= chip_rst_n && wr_hit(bus_i, PA_OFS_RCTL) &&
                       bus_i.wdata[PA_RCTL_SWRST_BIT];
   end

   // Pad drive selection.
   always_comb
   begin
      pad_next = '0;
      for (int i = 0; i < PA_NPIN; i++)
      begin
         if (PA_PIN_MASK[i])
         begin
            unique case (fn_of(i, fsel_reg))
               PA_FN_GPIO:
               begin
                  pad_next.out[i] = data_reg[i];
                  pad_next.oe[i]  = dir_reg[i];
               end
               PA_FN_PWM:
               begin
                  pad_next.out[i] = pwm_out[i];
                  pad_next.oe[i]  = 1'b1;
               end
               PA_FN_TIMER:
               begin
                  pad_next.out[i] = timer_out;
                  pad_next.oe[i]  = timer_oe;
               end
               PA_FN_FAULT:
               begin
                  pad_next.out[i] = 1'b0;
                  pad_next.oe[i]  = 1'b0;
               end
            endcase
         end
      end
      // The reset pad can only pull low, so a board reset line is never fought.
      pad_next.out[PA_RST_PIN] = 1'b0;
      pad_next.oe[PA_RST_PIN]  = rst_gpio_reg && dir_reg[PA_RST_PIN] &&
                                 !data_reg[PA_RST_PIN];
   end

   // Input routing to the timer channel and the PWM fault logic.
   always_comb
   begin
      timer_next = pad_in[PA_TMR_DEF];
      fault_next = 1'b0;
      for (int i = 0; i < PA_NFSEL; i++)
      begin
         if (fn_of(i, fsel_reg) == PA_FN_TIMER)
            timer_next = pad_in[i];
         if (fn_of(i, fsel_reg) == PA_FN_FAULT && pad_in[i])
            fault_next = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pad_o            <= '0;
         timer_in         <= 1'b0;
         pwm_fault_in_one <= 1'b0;
         gpio_in          <= 8'h00;
      end
      else
      begin
         pad_o            <= pad_next;
         timer_in         <= timer_next;
         pwm_fault_in_one <= fault_next;
         gpio_in          <= pad_in & PA_PIN_MASK;
      end
   end

   // Register reads; unmapped offsets read as zero.
   always_comb
   begin
      rdata_next = '0;
      unique case (bus_i.addr)
         PA_OFS_DATA: rdata_next[7:0] = data_reg;
         PA_OFS_DIR:  rdata_next[7:0] = dir_reg;
         PA_OFS_FSEL: rdata_next[9:0] = fsel_reg;
         PA_OFS_RCTL:
         begin
            rdata_next[PA_RCTL_GPIO_BIT] = rst_gpio_reg;
            rdata_next[PA_RCTL_STAT_BIT] = rst_gpio_reg || pad_in[PA_RST_PIN];
         end
         PA_OFS_PIN:  rdata_next[7:0] = pad_in & PA_PIN_MASK;
         default:     rdata_next = '0;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdata <= '0;
      else if (bus_i.rd)
         rdata <= rdata_next;
      else
         rdata <= '0;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   chk_reset_default: assert property (
      !chip_rst_n |=> fsel_reg == PA_FSEL_RST && !rst_gpio_reg && dir_reg == PA_DIR_RST)
      else $error("pin selects not back at defaults after reset");

   chk_ext_reset_hold: assert property (
      (!rst_gpio_reg && !pad_in[PA_RST_PIN]) |=> !chip_rst_n [*2])
      else $error("low reset pad did not reset the chip");

   chk_ext_reset_gate: assert property (
      (chip_rst_n && rst_gpio_reg && !por_req && !watchdog_reset && !sw_rst_reg)
      |=> chip_rst_n)
      else $error("reset pad in GPIO role reset the chip");

   chk_other_sources: assert property (
      (rst_gpio_reg && (por_req || watchdog_reset)) |=> !chip_rst_n)
      else $error("internal reset source ignored");

   chk_open_drain: assert property (
      pad_o.oe[PA_RST_PIN] |-> !pad_o.out[PA_RST_PIN] && $past(rst_gpio_reg))
      else $error("reset pad driven high or while in reset role");

   chk_pwm_drive: assert property (
      pa_fn_e'(fsel_reg[1:0]) == PA_FN_PWM |=> pad_o.oe[0] && pad_o.out[0] == $past(pwm_out[0]))
      else $error("PWM pin not driving its channel");

   chk_gpio_dir: assert property (
      pa_fn_e'(fsel_reg[3:2]) == PA_FN_GPIO
      |=> pad_o.oe[1] == $past(dir_reg[1]) && pad_o.out[1] == $past(data_reg[1]))
      else $error("GPIO pin ignores its own direction or data");

   chk_periph_owns: assert property (
      pa_fn_e'(fsel_reg[9:8]) == PA_FN_TIMER
      |=> pad_o.oe[4] == $past(timer_oe) && pad_o.out[4] == $past(timer_out))
      else $error("timer pin not owned by the timer");

   chk_fault_route: assert property (
      pa_fn_e'(fsel_reg[9:8]) == PA_FN_FAULT
      |=> pwm_fault_in_one == $past(pad_in[4]) && !pad_o.oe[4])
      else $error("fault pin not routed as input");

   // Not from the release edge, where the input flops still hold their reset values.
   chk_input_forward: assert property (
      nrst |=> timer_in == $past(pad_in[PA_TMR_DEF]) &&
      gpio_in[PA_RST_PIN] == $past(pad_in[PA_RST_PIN]))
      else $error("pad level not forwarded");

   // A software reset takes one cycle to register before the sequencer sees it.
   sequence s_sw_request;
      chip_rst_n && wr_hit(bus_i, PA_OFS_RCTL) && bus_i.wdata[PA_RCTL_SWRST_BIT];
   endsequence

   sequence s_chip_held;
      !chip_rst_n [*2];
   endsequence

   chk_sw_reset: assert property (
      s_sw_request |=> ##1 s_chip_held)
      else $error("software reset request ignored");

   chk_sel_stable: assert property (
      (chip_rst_n && !wr_hit(bus_i, PA_OFS_FSEL)) |=> fsel_reg == $past(fsel_reg))
      else $error("pin select changed without a write");

   chk_sel_write: assert property (
      (chip_rst_n && wr_hit(bus_i, PA_OFS_FSEL)) |=> fsel_reg == $past(bus_i.wdata[9:0]))
      else $error("pin select write not taken");

   chk_role_stable: assert property (
      (chip_rst_n && !wr_hit(bus_i, PA_OFS_RCTL)) |=> rst_gpio_reg == $past(rst_gpio_reg))
      else $error("reset pad role changed without a write");

   chk_data_gated: assert property (
      !chip_rst_n |=> data_reg == PA_DATA_RST)
      else $error("GPIO data not held at default during reset");

   chk_pwm_pin_three: assert property (
      pa_fn_e'(fsel_reg[7:6]) == PA_FN_PWM
      |=> pad_o.oe[3] && pad_o.out[3] == $past(pwm_out[3]))
      else $error("PWM pin three not driving its channel");

   chk_fault_only_sel: assert property (
      pa_fn_e'(fsel_reg[9:8]) != PA_FN_FAULT |=> !pwm_fault_in_one)
      else $error("fault flagged on a pin not set to fault");

   chk_pad_read: assert property (
      (bus_i.rd && bus_i.addr == PA_OFS_PIN)
      |=> rdata[7:0] == ($past(pad_in) & PA_PIN_MASK))
      else $error("pin register does not show the pad levels");

   chk_rpad_role_oe: assert property (
      !rst_gpio_reg |=> !pad_o.oe[PA_RST_PIN])
      else $error("reset pad driven while in reset role");

endmodule : pa_pin_mux

// File: pa_pin_mux_bench.sv
// Purpose: Self-checking bench for the port A pin function select block.
// Assumes: Board model resolves the pads; reset hold count is shortened.
// Notes:   Each scenario is a task; every run ends in conclude.
`timescale 1ns/10ps
module pa_pin_mux_bench
   import pa_pkg::*;
;
   localparam int HOLD = 4;
   logic               clk;
   logic               nrst;
   pa_bus_s            bus;
   logic [PA_DW-1:0]   rdata;
   logic [PA_NPIN-1:0] pad_in;
   pa_pad_s            pad_o;
   logic [PA_NPWM-1:0] pwm_out;
   logic               timer_out;
   logic               timer_oe;
   logic               timer_in;
   logic               fault;
   logic [PA_NPIN-1:0] gpio_in;
   logic               por_req;
   logic               wd_req;
   logic               chip_rst_n;
   logic [7:0]         ext_val;
   logic [7:0]         ext_en;
   int                 n_mismatch;
   int                 num_checks;
   int                 n;

   pa_pin_mux #(.HOLD_CYCLES(HOLD)) dut (.clk(clk), .nrst(nrst), .bus_i(bus), .rdata(rdata),
      .pad_in(pad_in), .pad_o(pad_o), .pwm_out(pwm_out), .timer_out(timer_out),
      .timer_oe(timer_oe), .timer_in(timer_in), .pwm_fault_in_one(fault), .gpio_in(gpio_in),
      .por_req(por_req), .watchdog_reset(wd_req), .chip_rst_n(chip_rst_n));
   pa_board board (.pad_o(pad_o), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

   always #5 clk = ~clk;

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   task automatic rdchk(input string what, input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk(what, exp, rdata);
   endtask : rdchk

   task automatic drive_ext(input logic [7:0] en, input logic [7:0] val);
      @(posedge clk);
      ext_en <= en;
      ext_val <= val;
   endtask : drive_ext

   // Bounded wait, so a chip stuck in reset still lets the run finish.
   task automatic wait_up(output int k);
      k = 0;
      while (chip_rst_n !== 1'b1 && k < 64)
      begin
         tick(1);
         k++;
      end
   endtask : wait_up

   task automatic t_defaults;
      rdchk("data", PA_OFS_DATA, 16'h0000);
      rdchk("dir", PA_OFS_DIR, 16'h0000);
      rdchk("fsel", PA_OFS_FSEL, 16'h0000);
      rdchk("rctl", PA_OFS_RCTL, 16'h0004);
      chk("oe", 16'h0000, {8'h00, pad_o.oe});
      $display("test defaults done");
   endtask : t_defaults

   task automatic t_gpio;
      wr(PA_OFS_DATA, 16'h0014);
      wr(PA_OFS_DIR, 16'h0005);
      drive_ext(8'h08, 8'h00);
      tick(2);
      chk("oe", 16'h0005, {8'h00, pad_o.oe});
      chk("out", 16'h0004, {8'h00, pad_o.out & pad_o.oe});
      rdchk("pin", PA_OFS_PIN, 16'h0096);
      chk("gpio_in", 16'h0096, {8'h00, gpio_in});
      rdchk("unmapped", 4'hF, 16'h0000);
      wr(PA_OFS_DIR, 16'h000A);
      tick(2);
      chk("oe", 16'h000A, {8'h00, pad_o.oe});
      $display("test gpio done");
   endtask : t_gpio

   task automatic t_pwm;
      wr(PA_OFS_DIR, 16'h0000);
      @(posedge clk);
      pwm_out <= 6'h2A;
      wr(PA_OFS_FSEL, 16'h0155);
      tick(2);
      chk("pwm_oe", 16'h001F, {8'h00, pad_o.oe});
      chk("pwm_out", 16'h000A, {11'h000, pad_o.out[4:0]});
      @(posedge clk);
      pwm_out <= 6'h15;
      wr(PA_OFS_DATA, 16'h001F);
      tick(2);
      chk("pwm_out", 16'h0015, {11'h000, pad_o.out[4:0]});
      rdchk("fsel", PA_OFS_FSEL, 16'h0155);
      wr(PA_OFS_FSEL, 16'h0000);
      tick(2);
      chk("gpio_oe", 16'h0000, {8'h00, pad_o.oe});
      $display("test pwm done");
   endtask : t_pwm

   task automatic t_timer;
      @(posedge clk);
      timer_out <= 1'b1;
      timer_oe <= 1'b1;
      wr(PA_OFS_FSEL, 16'h0200);
      tick(2);
      chk("tmr_oe", 16'h0010, {8'h00, pad_o.oe});
      chk("tmr_out", 16'h0001, {15'h0000, pad_o.out[4]});
      @(posedge clk);
      timer_oe <= 1'b0;
      drive_ext(8'h10, 8'h00);
      tick(2);
      chk("tmr_in", 16'h0000, {15'h0000, timer_in});
      drive_ext(8'h10, 8'h10);
      tick(2);
      chk("tmr_in", 16'h0001, {15'h0000, timer_in});
      $display("test timer done");
   endtask : t_timer

   task automatic t_fault;
      wr(PA_OFS_DIR, 16'h0010);
      wr(PA_OFS_FSEL, 16'h0300);
      tick(2);
      chk("flt", 16'h0001, {15'h0000, fault});
      chk("flt_oe", 16'h0000, {8'h00, pad_o.oe});
      drive_ext(8'h10, 8'h00);
      tick(2);
      chk("flt", 16'h0000, {15'h0000, fault});
      wr(PA_OFS_FSEL, 16'h0000);
      wr(PA_OFS_DIR, 16'h0000);
      drive_ext(8'h00, 8'h00);
      tick(2);
      chk("flt_gpio", 16'h0000, {15'h0000, fault});
      wr(PA_OFS_DIR, 16'h000F);
      wr(PA_OFS_FSEL, 16'h00FF);
      tick(2);
      chk("bad_code_oe", 16'h000F, {8'h00, pad_o.oe});
      rdchk("fsel", PA_OFS_FSEL, 16'h00FF);
      $display("test fault done");
   endtask : t_fault

   task automatic t_rpad;
      int k;
      drive_ext(8'h80, 8'h00);
      tick(3);
      chk("pad_rst", 16'h0000, {15'h0000, chip_rst_n});
      wr(PA_OFS_DATA, 16'h0001);
      drive_ext(8'h00, 8'h00);
      wait_up(k);
      chk("hold", 16'h0001, {15'h0000, k >= HOLD && k <= HOLD + 1});
      rdchk("data", PA_OFS_DATA, 16'h0000);
      wr(PA_OFS_RCTL, 16'h0001);
      wr(PA_OFS_DIR, 16'h0080);
      wr(PA_OFS_DATA, 16'h0000);
      tick(4);
      chk("od_oe", 16'h0080, {8'h00, pad_o.oe});
      chk("od_out", 16'h0000, {8'h00, pad_o.out & 8'h80});
      chk("gated", 16'h0001, {15'h0000, chip_rst_n});
      rdchk("pin", PA_OFS_PIN, 16'h001F);
      wr(PA_OFS_DATA, 16'h0080);
      tick(2);
      chk("od_rel", 16'h0000, {8'h00, pad_o.oe});
      $display("test reset pad done");
   endtask : t_rpad

   task automatic t_sources;
      int k;
      for (int s = 0; s < 3; s++)
      begin
         wr(PA_OFS_RCTL, 16'h0001);
         @(posedge clk);
         por_req <= (s == 0);
         wd_req <= (s == 1);
         @(posedge clk);
         por_req <= 1'b0;
         wd_req <= 1'b0;
         if (s == 2)
            wr(PA_OFS_RCTL, 16'h0003);
         tick(2);
         chk("src_rst", 16'h0000, {15'h0000, chip_rst_n});
         wait_up(k);
         chk("src_up", 16'h0001, {15'h0000, chip_rst_n});
         rdchk("rctl", PA_OFS_RCTL, 16'h0004);
      end
      $display("test reset sources done");
   endtask : t_sources

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude

   initial
   begin
      clk = 1'b0;
      nrst = 1'b0;
      bus = '0;
      pwm_out = '0;
      timer_out = 1'b0;
      timer_oe = 1'b0;
      por_req = 1'b0;
      wd_req = 1'b0;
      ext_val = 8'h00;
      ext_en = 8'h00;
      n_mismatch = 0;
      num_checks = 0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      wait_up(n);
      chk("hold", 16'h0001, {15'h0000, n >= HOLD && n <= HOLD + 1});
      t_defaults;
      t_gpio;
      t_pwm;
      t_timer;
      t_fault;
      t_rpad;
      t_sources;
      conclude;
   end

   // The tests need well under a thousand cycles; this allows ten times that.
   initial
   begin
      #100000;
      n_mismatch++;
      conclude;
   end
endmodule : pa_pin_mux_bench

// File: pa_pkg.sv
// Purpose: Shared constants and types for the port A pin function select block.
// Assumes: One 100 MHz clock; register port with read data one cycle later.
// Notes:   Bit index of every pin vector equals the port A bit number.
package pa_pkg;

   localparam int PA_AW     = 4;
   localparam int PA_DW     = 16;
   localparam int PA_NPIN   = 8;
   localparam int PA_NPWM   = 6;
   localparam int PA_NFSEL  = 5;
   localparam int PA_FSEL_W = 2;

   // Register offsets on the register port.
   localparam logic [3:0] PA_OFS_DATA = 4'h0;
   localparam logic [3:0] PA_OFS_DIR  = 4'h1;
   localparam logic [3:0] PA_OFS_FSEL = 4'h2;
   localparam logic [3:0] PA_OFS_RCTL = 4'h3;
   localparam logic [3:0] PA_OFS_PIN  = 4'h4;

   // Field positions in the reset pad control register.
   localparam int PA_RCTL_GPIO_BIT  = 0;
   localparam int PA_RCTL_SWRST_BIT = 1;
   localparam int PA_RCTL_STAT_BIT  = 2;

   // Pins handled here and the functions each one can take.
   localparam logic [7:0] PA_PIN_MASK = 8'h9F;
   localparam logic [7:0] PA_PWM_MASK = 8'h1F;
   localparam logic [7:0] PA_TMR_MASK = 8'h10;
   localparam logic [7:0] PA_FLT_MASK = 8'h10;
   localparam int         PA_RST_PIN  = 7;
   localparam int         PA_TMR_DEF  = 4;

   // Values after reset.
   localparam logic [7:0] PA_DATA_RST  = 8'h00;
   localparam logic [7:0] PA_DIR_RST   = 8'h00;
   localparam logic [9:0] PA_FSEL_RST  = 10'h000;
   localparam logic       PA_RGPIO_RST = 1'b0;

   // Internal clocks that the chip reset stays low after the last request.
   localparam int PA_RST_HOLD_CYC = 16;

   typedef enum logic [1:0] {PA_FN_GPIO, PA_FN_PWM, PA_FN_TIMER, PA_FN_FAULT} pa_fn_e;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pa_pad_s;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } pa_bus_s;

endpackage : pa_pkg

// File: pa_rst_seq.sv
// Purpose: Chip reset sequencer; stretches any reset request to a fixed count.
// Assumes: Requests are synchronous to clk.
// Notes:   Release happens on a clk edge, so the chip leaves reset cleanly.
`timescale 1ns/10ps
module pa_rst_seq
   import pa_pkg::*;
#(
   parameter int HOLD_CYCLES = PA_RST_HOLD_CYC
)(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic req,
   output logic      rst_n_o
);

   generate
      if (HOLD_CYCLES < 2 || HOLD_CYCLES > 65535)
      begin : g_bad
         $error("HOLD_CYCLES out of range");
      end
   endgenerate

   logic [15:0] cnt_reg;
   logic [15:0] quiet_reg;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_n_o <= 1'b0;
         cnt_reg <= 16'h0000;
      end
      else if (req)
      begin
         rst_n_o <= 1'b0;
         cnt_reg <= 16'h0000;
      end
      else if (!rst_n_o)
      begin
         if (cnt_reg == 16'(HOLD_CYCLES - 1))
            rst_n_o <= 1'b1;
         else
            cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // Quiet cycle counter read only by the checks below.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         quiet_reg <= 16'h0000;
      else if (req)
         quiet_reg <= 16'h0000;
      else if (quiet_reg != 16'hFFFF)
         quiet_reg <= quiet_reg + 16'h0001;
   end

   sequence s_held;
      !rst_n_o [*2];
   endsequence

   property p_hold_low;
      @(posedge clk) disable iff (!nrst) req |=> s_held;
   endproperty

   chk_release_count: assert property (@(posedge clk) disable iff (!nrst)
      $rose(rst_n_o) |-> quiet_reg == 16'(HOLD_CYCLES))
      else $error("chip reset released after wrong count");

   chk_request_holds: assert property (p_hold_low)
      else $error("chip reset not held after request");

endmodule : pa_rst_seq
